//--- rtl/sqfi_top.sv
// Device side of the serial flash interface: pin engine, busy engine, registers.
// Assumes all pins are asynchronous to ref_clk and the serial clock is slow.
//
// Our own choices: the address map and register access over Wishbone.
`timescale 1ns/100ps
// Function
// - Input bits taken on serial clock rise, output bits driven on its fall.
// - Enter-quad command turns all four data lines into two-way nibble lines.
// - After reset, single-bit mode: line 0 carries input, line 1 output.
// - A falling select starts a transaction; host makes that edge per command.
// - Guard pin, guard enable and io config decide refusal of protection writes.
// - Guard and pause pins are ignored in four-bit operation.
// - Pause low freezes communication while selected; host holds it high otherwise.
// - Build variant picks power-up pin function: guard and pause pins honoured or ignored.
// - Page program takes up to 256 bytes, single or four-bit.
// - Reads burst linearly or wrap in an 8, 16, 32 or 64 byte window.
// - Busy bit shows program or erase; host polls it.
// - Program or erase can be suspended for other accesses, then resumed.
// - 2 KByte one-time area with a 64 bit factory id and user region.
// - Top and bottom 8 KByte blocks can be read-locked and write-locked.
// - In four-bit mode command, address and data all use four lines.
module sqfi_top
  import sqfi_pkg::*;
#(
  parameter bit          QUAD_VARIANT = 1'b0,
  parameter logic [63:0] UNIQUE_ID    = 64'h0123_4567_89ab_cdef, // Arbitrary value
  parameter int          MEM_AW       = MAIN_AW
) (
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  input  wire logic             serial_clk,
  input  wire logic             device_select_n,
  input  wire logic             pause_pin_n,
  input  wire logic             write_guard_pin_n,
  input  wire logic [3:0]       quad_data_lines_in,
  output logic      [3:0]       quad_data_lines_out,
  output logic      [3:0]       quad_data_lines_oe,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [WB_AW-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  output logic                  irq
);

  localparam logic [MEM_AW-1:0] PROG_LAST = MEM_AW'(PROG_CYC - 1);

  typedef struct packed {
    logic [7:0]      s1;
    logic [7:0]      s2;
    logic            sck_q;
    logic            cs_q;
    logic            sel;
    sqfi_st_t        st;
    logic            quad;
    logic [7:0]      cmd;
    logic [7:0]      sh;
    logic [7:0]      obuf;
    logic [2:0]      bits;
    logic [2:0]      obits;
    logic [1:0]      ab;
    logic [23:0]     addr;
    logic            arm;
    logic            wrote;
    logic [3:0]      dout;
    logic [3:0]      doe;
    logic            wel;
    logic [3:0]      bpr;
    logic [1:0]      wrap;
    logic            busy;
    logic            susp;
    logic            erase;
    logic [MEM_AW-1:0] bcnt;
    logic            write_guard_pin_enable;
    logic            io_config_select;
    logic [2:0]      ists;
    logic [2:0]      ien;
    logic            irq;
    logic            ack;
    logic [31:0]     dat;
    logic            we;
    logic [MEM_AW:0] waddr;
    logic [MEM_AW:0] raddr;
    logic [7:0]      wdata;
  } sqfi_top_st_t;

  sqfi_top_st_t s;
  sqfi_top_st_t n;
  logic         sck;
  logic         csn;
  logic [3:0]   din;
  logic         rise;
  logic         fall;
  logic         cs_rise;
  logic         pins_on;
  logic         pause_act;
  logic         guard_blk;
  logic         act;
  logic [2:0]   step;
  logic [2:0]   rx_bits;
  logic         rx_done;
  logic [7:0]   rx_byte;
  logic         is_sid;
  logic         is_uid;
  logic [7:0]   rbyte;
  logic [7:0]   sr;

  sqfi_mem_if #(.AW(MEM_AW + 1)) mbus ();

  sqfi_mem #(.AW(MEM_AW + 1)) u_mem (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .port    (mbus.mem)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic wlock(input logic [23:0] a, input logic [3:0] b);
    wlock = (a < BOT_END && b[0]) || (a >= TOP_BEG && b[1]);
  endfunction

  function automatic logic rlock(input logic [23:0] a, input logic [3:0] b);
    rlock = (a < BOT_END && b[2]) || (a >= TOP_BEG && b[3]);
  endfunction

  function automatic logic [MEM_AW:0] maddr(input logic [23:0] a, input logic id);
    maddr = id ? {1'b1, MEM_AW'(a[SID_AW-1:0])} : {1'b0, a[MEM_AW-1:0]};
  endfunction

  function automatic logic [23:0] rd_inc(input logic [23:0] a, input logic w,
                                         input logic [1:0] wl);
    logic [5:0] m;
    m = 6'((7'h08 << wl) - 7'h01);
    rd_inc = w ? {a[23:6], (a[5:0] & ~m) | ((a[5:0] + 6'd1) & m)} : a + 24'd1;
  endfunction

  // ----------------------------------------
  // Pin view
  // ----------------------------------------
  assign sck       = s.s2[0];
  assign csn       = s.s2[1];
  assign din       = s.s2[7:4];
  assign rise      = sck && !s.sck_q;
  assign fall      = !sck && s.sck_q;
  assign cs_rise   = csn && !s.cs_q;
  assign pins_on   = !s.io_config_select && !s.quad;
  assign pause_act = pins_on && !s.s2[2];
  assign guard_blk = pins_on && s.write_guard_pin_enable && !s.s2[3];
  assign act       = s.sel && !csn && !pause_act;
  assign step      = s.quad ? 3'd4 : 3'd1;
  assign rx_bits   = s.bits + step;
  assign rx_done   = (rx_bits == 3'd0);
  assign rx_byte   = s.quad ? {s.sh[3:0], din} : {s.sh[6:0], din[0]};
  assign is_sid    = (s.cmd == CMD_RD_ID) || (s.cmd == CMD_PROG_ID);
  assign is_uid    = (s.addr[SID_AW-1:3] == '0);
  assign sr        = {4'h0, s.quad, s.susp, s.wel, s.busy};

  // ----------------------------------------
  // Read byte selection
  // ----------------------------------------
  always_comb begin
    rbyte = mbus.rdata;
    if (is_sid && is_uid) begin
      rbyte = 8'(UNIQUE_ID >> {3'd7 - s.addr[2:0], 3'b000});
    end else if (!is_sid && rlock(s.addr, s.bpr)) begin
      rbyte = 8'h00;
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [2:0]  ev;
    logic [2:0]  clr;
    logic [31:0] rd;
    logic [7:0]  ob;
    ev       = 3'b000;
    clr      = 3'b000;
    rd       = 32'h0;
    ob       = s.obuf;
    n        = s;
    n.we     = 1'b0;
    n.ack    = 1'b0;
    n.s1     = {quad_data_lines_in, write_guard_pin_n, pause_pin_n, device_select_n,
                serial_clk};
    n.s2     = s.s1;
    n.sck_q  = sck;
    n.cs_q   = csn;
    if (!csn && s.cs_q) begin
      n.sel = 1'b1;
    end

    // Internal operation; suspend freezes the count
    if (s.busy && !s.susp) begin
      n.bcnt = s.bcnt + 1'b1;
      if (s.erase) begin
        n.we    = 1'b1;
        n.waddr = {1'b0, s.bcnt};
        n.wdata = 8'hff;
      end
      if (s.erase ? &s.bcnt : s.bcnt == PROG_LAST) begin
        n.busy  = 1'b0;
        n.erase = 1'b0;
        n.susp  = 1'b0;
        ev[EV_DONE] = 1'b1;
      end
    end

    if (csn) begin
      n.sel   = 1'b0;
      n.st    = ST_IDLE;
      n.bits  = 3'd0;
      n.obits = 3'd0;
      n.doe   = 4'h0;
      n.ab    = 2'd0;
      n.arm   = 1'b0;
      n.wrote = 1'b0;
      if (cs_rise) begin
        ev[EV_CMD] = 1'b1;
        if (s.wrote && !s.busy) begin
          n.busy  = 1'b1;
          n.erase = 1'b0;
          n.bcnt  = '0;
          n.wel   = 1'b0;
        end
        if (s.arm) begin
          if (s.wel && !wlock(s.addr, s.bpr)) begin
            n.busy  = 1'b1;
            n.erase = 1'b1;
            n.bcnt  = '0;
          end else begin
            ev[EV_REFUSE] = 1'b1;
          end
          n.wel = 1'b0;
        end
      end
    end else if (act && rise) begin
      n.sh   = rx_byte;
      n.bits = rx_bits;
      if (rx_done) begin
        case (s.st)
          ST_IDLE: begin
            n.cmd = rx_byte;
            n.st  = ST_IGN;
            n.ab  = 2'd0;
            case (rx_byte)
              CMD_WRITE_EN:   n.wel = 1'b1;
              CMD_ENTER_QUAD: n.quad = 1'b1;
              CMD_LEAVE_QUAD: n.quad = 1'b0;
              CMD_STATUS:     n.st = ST_DOUT;
              CMD_SUSPEND:    n.susp = s.busy;
              CMD_RESUME:     n.susp = 1'b0;
              CMD_WR_PROT, CMD_SET_WRAP: n.st = ST_DIN;
              CMD_READ, CMD_READ_WRAP, CMD_RD_ID, CMD_PROG, CMD_PROG_ID: begin
                if (!s.busy || s.susp) begin
                  n.st = ST_ADDR;
                end
              end
              CMD_ERASE: begin
                if (!s.busy) begin
                  n.st = ST_ADDR;
                end
              end
              default: n.st = ST_IGN;
            endcase
          end
          ST_ADDR: begin
            n.addr = {s.addr[15:0], rx_byte};
            n.ab   = s.ab + 2'd1;
            if (s.ab == 2'd2) begin
              if (s.cmd inside {CMD_READ, CMD_READ_WRAP, CMD_RD_ID}) begin
                n.st    = ST_DOUT;
                n.raddr = maddr(n.addr, is_sid);
              end else if (s.cmd == CMD_ERASE) begin
                n.arm = 1'b1;
                n.st  = ST_IGN;
              end else begin
                n.st = ST_DIN;
              end
            end
          end
          ST_DIN: begin
            if (s.cmd == CMD_SET_WRAP) begin
              n.wrap = rx_byte[1:0];
              n.st   = ST_IGN;
            end else if (s.cmd == CMD_WR_PROT) begin
              if (s.wel && !guard_blk) begin
                n.bpr = rx_byte[3:0];
              end else begin
                ev[EV_REFUSE] = 1'b1;
              end
              n.wel = 1'b0;
              n.st  = ST_IGN;
            end else begin
              if (s.wel && (is_sid ? !is_uid : !wlock(s.addr, s.bpr))) begin
                n.we    = 1'b1;
                n.waddr = maddr(s.addr, is_sid);
                n.wdata = rx_byte;
                n.wrote = 1'b1;
              end else begin
                ev[EV_REFUSE] = 1'b1;
              end
              n.addr = {s.addr[23:PAGE_AW], s.addr[PAGE_AW-1:0] + 8'd1};
            end
          end
          default: n.st = s.st;
        endcase
      end
    end else if (act && fall && s.st == ST_DOUT) begin
      if (s.obits == 3'd0) begin
        ob = (s.cmd == CMD_STATUS) ? sr : rbyte;
        if (s.cmd != CMD_STATUS) begin
          n.addr  = rd_inc(s.addr, s.cmd == CMD_READ_WRAP, s.wrap);
          n.raddr = maddr(n.addr, is_sid);
        end
      end
      n.dout  = s.quad ? ob[7:4] : {2'b00, ob[7], 1'b0};
      n.obuf  = s.quad ? {ob[3:0], 4'h0} : {ob[6:0], 1'b0};
      n.obits = s.obits + step;
      n.doe   = s.quad ? 4'hf : 4'h2;
    end

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    if (wb_cyc_i && wb_stb_i && !s.ack) begin
      n.ack = 1'b1;
      if (wb_adr_i == A_CTRL) begin
        rd = {28'h0, s.wrap, s.io_config_select, s.write_guard_pin_enable};
        if (wb_we_i && wb_sel_i[0]) begin
          n.write_guard_pin_enable = wb_dat_i[0];
          n.io_config_select       = wb_dat_i[1];
        end
      end else if (wb_adr_i == A_STAT) begin
        rd = {24'h0, s.bpr, sr[3:0]};
      end else if (wb_adr_i == A_ISTS) begin
        rd = {29'h0, s.ists};
      end else if (wb_adr_i == A_ICLR) begin
        if (wb_we_i && wb_sel_i[0]) begin
          clr = wb_dat_i[2:0];
        end
      end else if (wb_adr_i == A_IEN) begin
        rd = {29'h0, s.ien};
        if (wb_we_i && wb_sel_i[0]) begin
          n.ien = wb_dat_i[2:0];
        end
      end
      n.dat = rd;
    end
    // A new event beats a clear in the same cycle
    n.ists = (s.ists & ~clr) | ev;
    n.irq  = |(n.ists & n.ien);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s                  <= '0;
      s.s1               <= SYNC_RST;
      s.s2               <= SYNC_RST;
      s.cs_q             <= 1'b1;
      s.st               <= ST_IDLE;
      s.io_config_select <= QUAD_VARIANT;
    end else begin
      s <= n;
    end
  end

  assign quad_data_lines_out = s.dout;
  assign quad_data_lines_oe  = s.doe;
  assign wb_dat_o            = s.dat;
  assign wb_ack_o            = s.ack;
  assign irq                 = s.irq;
  assign mbus.we             = s.we;
  assign mbus.waddr          = s.waddr;
  assign mbus.wdata          = s.wdata;
  assign mbus.raddr          = s.raddr;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence quad_cmd_in;
    s.st == ST_IDLE && act && rise && rx_done && rx_byte == CMD_ENTER_QUAD;
  endsequence

  sequence guard_write;
    s.st == ST_DIN && s.cmd == CMD_WR_PROT && act && rise && rx_done;
  endsequence

  a_in_on_rise: assert property (!rise |=> $stable(s.sh))
    else $error("input shifted without a rising edge");
  a_out_on_fall: assert property (!fall |=> $stable(s.dout))
    else $error("output changed without a falling edge");
  a_quad_entry: assert property (quad_cmd_in |=> s.quad)
    else $error("four-bit mode not entered");
  a_single_lines: assert property (!s.quad |-> s.doe inside {4'h0, 4'h2})
    else $error("single-bit mode drives a wrong line");
  a_select_edge: assert property (!s.sel ##1 s.sel |-> $past(s.cs_q))
    else $error("selected without a falling select");
  a_guard_refuse: assert property (guard_write and guard_blk |=> $stable(s.bpr))
    else $error("protection write not refused");
  a_pause_freeze: assert property (pause_act |=> $stable(s.sh) && $stable(s.dout))
    else $error("transfer moved while paused");
  a_page_wrap: assert property (s.st == ST_DIN && s.cmd == CMD_PROG && act && rise
      && rx_done && s.addr[7:0] == 8'hff |=> s.addr[7:0] == 8'h00 && $stable(s.addr[23:8]))
    else $error("page address left its page");
  a_busy_start: assert property ($rose(s.busy) |-> $past(cs_rise))
    else $error("busy rose without a deselect");
  a_suspend_hold: assert property (s.busy && s.susp |=> $stable(s.bcnt))
    else $error("suspended operation advanced");
  a_quad_lines: assert property (s.quad && s.doe != 4'h0 |-> s.doe == 4'hf)
    else $error("four-bit output not on all lines");
  a_read_lock: assert property (act && fall && s.st == ST_DOUT && s.obits == 3'd0
      && s.cmd == CMD_READ && rlock(s.addr, s.bpr) |=> s.dout == 4'h0)
    else $error("read-locked byte leaked");
  a_deselect_idle: assert property (csn |=> s.st == ST_IDLE && s.doe == 4'h0)
    else $error("deselect did not end the transaction");

endmodule

//--- rtl/sqfi_pkg.sv
// Constants, command codes, register map and state codes of the serial flash interface.
// Assumes a 10 MHz ref_clk and a host serial clock far slower than it.
package sqfi_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int MAIN_AW   = 12;
  localparam int SID_AW    = 11;
  localparam int PAGE_AW   = 8;
  localparam int WB_AW     = 8;
  localparam logic [23:0] BOT_END = 24'h002000;
  localparam logic [23:0] TOP_BEG = 24'h3fe000;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS    = 100;
  localparam int PROG_NS   = 25000;
  localparam int PROG_CYC  = (PROG_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------
  // Serial commands
  // ----------------------------------------
  localparam logic [7:0] CMD_READ       = 8'h03;
  localparam logic [7:0] CMD_READ_WRAP  = 8'h0c;
  localparam logic [7:0] CMD_PROG       = 8'h02;
  localparam logic [7:0] CMD_ERASE      = 8'h20;
  localparam logic [7:0] CMD_STATUS     = 8'h05;
  localparam logic [7:0] CMD_WRITE_EN   = 8'h06;
  localparam logic [7:0] CMD_ENTER_QUAD = 8'h38;
  localparam logic [7:0] CMD_LEAVE_QUAD = 8'hff;
  localparam logic [7:0] CMD_SUSPEND    = 8'hb0;
  localparam logic [7:0] CMD_RESUME     = 8'h30;
  localparam logic [7:0] CMD_WR_PROT    = 8'h42;
  localparam logic [7:0] CMD_SET_WRAP   = 8'hc0;
  localparam logic [7:0] CMD_RD_ID      = 8'h88;
  localparam logic [7:0] CMD_PROG_ID    = 8'ha5;

  // ----------------------------------------
  // Register map and fields
  // ----------------------------------------
  localparam logic [WB_AW-1:0] A_CTRL  = 8'h00;
  localparam logic [WB_AW-1:0] A_STAT  = 8'h04;
  localparam logic [WB_AW-1:0] A_ISTS  = 8'h08;
  localparam logic [WB_AW-1:0] A_ICLR  = 8'h0c;
  localparam logic [WB_AW-1:0] A_IEN   = 8'h10;
  localparam int EV_CMD    = 0;
  localparam int EV_DONE   = 1;
  localparam int EV_REFUSE = 2;
  localparam logic [7:0] SYNC_RST = 8'h0e;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_DIN  = 5'b00100,
    ST_DOUT = 5'b01000,
    ST_IGN  = 5'b10000
  } sqfi_st_t;

endpackage

//--- rtl/sqfi_mem_if.sv
// Port bundle between the serial engine and its byte memory.
// Assumes one write and one registered read per cycle.
`timescale 1ns/100ps
interface sqfi_mem_if #(parameter int AW = 13);
  logic          we;
  logic [AW-1:0] waddr;
  logic [AW-1:0] raddr;
  logic [7:0]    wdata;
  logic [7:0]    rdata;
  modport ctl (output we, waddr, raddr, wdata, input rdata);
  modport mem (input we, waddr, raddr, wdata, output rdata);
endinterface

//--- rtl/sqfi_mem.sv
// Byte memory: main array in the low half, identification area in the upper half.
// Assumes writes and reads come from one clock; content is unset until written.
`timescale 1ns/100ps
module sqfi_mem
  import sqfi_pkg::*;
#(
  parameter int AW = 13
) (
  input wire logic ref_clk,
  input wire logic nrst,
  sqfi_mem_if.mem  port
);

  typedef struct packed {
    logic [7:0] rdata;
  } sqfi_mem_st_t;

  logic [7:0]   arr [2**AW];
  sqfi_mem_st_t s;
  sqfi_mem_st_t next_s;

  always_comb begin
    next_s       = s;
    next_s.rdata = arr[port.raddr];
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // No reset on the array: it stands for non-volatile cells
  always_ff @(posedge ref_clk) begin
    if (port.we) begin
      arr[port.waddr] <= port.wdata;
    end
  end

  assign port.rdata = s.rdata;

endmodule

//--- bench/sqfi_host.sv
// Host serial controller model: serial clock, select and data lines.
// Assumes ref_clk at 10 MHz; serial clock period is 8 ref_clk cycles.
`timescale 1ns/100ps
module sqfi_host (
  input  wire logic       ref_clk,
  input  wire logic [3:0] lines,
  output logic            serial_clk,
  output logic            device_select_n,
  output logic [3:0]      h_out,
  output logic [3:0]      h_oe
);
  initial begin
    serial_clk = 1'b0;
    device_select_n = 1'b1;
    h_out = 4'h0;
    h_oe = 4'h0;
  end
  // Clock idles low between frames; bytes MSB first
  task automatic xfer(input logic [7:0] tx, input bit q, input bit rd,
                      output logic [7:0] rx);
    logic [7:0] s;
    s = tx;
    rx = 8'h00;
    for (int i = 0; i < (q ? 2 : 8); i++) begin
      h_oe <= q ? (rd ? 4'h0 : 4'hf) : 4'h1;
      h_out <= q ? s[7:4] : {3'h0, s[7]};
      s = q ? s << 4 : s << 1;
      repeat (4) @(posedge ref_clk);
      rx = q ? {rx[3:0], lines} : {rx[6:0], lines[1]};
      serial_clk <= 1'b1;
      repeat (4) @(posedge ref_clk);
      serial_clk <= 1'b0;
    end
  endtask
  // One falling select per command, held low to the last byte
  task automatic frame(input logic [7:0] b [6], input int nb, input int nrd,
                       input bit q, output logic [15:0] r);
    logic [7:0] x;
    r = 16'h0;
    device_select_n <= 1'b0;
    for (int i = 0; i < nb + nrd; i++) begin
      xfer(i < nb ? b[i] : 8'h00, q, i >= nb, x);
      r = {r[7:0], x};
    end
    repeat (4) @(posedge ref_clk);
    device_select_n <= 1'b1;
    h_oe <= 4'h0;
    repeat (8) @(posedge ref_clk);
  endtask
endmodule

//--- bench/serial_quad_flash_interface_bench.sv
// Bench for the serial flash interface: host model, bus master, checks.
// Assumes the default build variant and a 10 MHz ref_clk.
`timescale 1ns/100ps
module serial_quad_flash_interface_bench
  import sqfi_pkg::*;
;
  logic        ref_clk, nrst, pause_pin_n, guard_n, noise;
  logic        wb_cyc, wb_stb, wb_we, wb_ack_o, irq, sclk, csn;
  logic [7:0]  wb_adr;
  logic [31:0] wb_dat, wb_dat_o, rd;
  logic [3:0]  q_out, q_oe, h_out, h_oe, lines;
  logic [15:0] r;
  int          fails, check_count;
  localparam logic [63:0] ID_VAL = 64'h5a3c_0f96_1e2d_4b87; // Arbitrary value
  // Released lines wander so a missing drive cannot pass
  assign lines = (q_oe & q_out) | (~q_oe & ((h_oe & h_out) | (~h_oe & {4{noise}})));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) noise <= (noise !== 1'b1);
  sqfi_top #(.UNIQUE_ID(ID_VAL)) dut (.ref_clk(ref_clk), .nrst(nrst), .serial_clk(sclk),
    .device_select_n(csn), .pause_pin_n(pause_pin_n), .write_guard_pin_n(guard_n),
    .quad_data_lines_in(lines), .quad_data_lines_out(q_out), .quad_data_lines_oe(q_oe),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq(irq));
  sqfi_host host (.ref_clk(ref_clk), .lines(lines), .serial_clk(sclk),
    .device_select_n(csn), .h_out(h_out), .h_oe(h_oe));
  task automatic end_sim();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      $display("[ERR] %0t got %h exp %h", $time, g, e);
      fails++;
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    do begin
      @(posedge ref_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o;
    if (k >= 20) begin
      fails++;
      end_sim();
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  task automatic sf(input logic [7:0] c, input logic [23:0] a, input int nb,
                    input int nrd, input bit q);
    host.frame('{c, a[23:16], a[15:8], a[7:0], 8'ha5, 8'h3c}, nb, nrd, q, r);
  endtask
  task automatic t_reset();
    rc(A_CTRL, 32'h3, 32'h0);
    rc(A_STAT, 32'hf, 32'h0);
    rc(8'h40, 32'hffffffff, 32'h0);
  endtask
  task automatic t_irq();
    sf(CMD_STATUS, 24'h0, 1, 1, 1'b0);
    rc(A_ISTS, 32'h1, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, A_IEN, 32'h1);
    @(posedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    wb(1'b1, A_ICLR, 32'h7);
    @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, A_IEN, 32'h0);
  endtask
  task automatic t_prog();
    int k;
    sf(CMD_WRITE_EN, 24'h0, 1, 0, 1'b0);
    sf(CMD_WR_PROT, 24'h0, 2, 0, 1'b0);
    rc(A_STAT, 32'hf0, 32'h0);
    sf(CMD_WRITE_EN, 24'h0, 1, 0, 1'b0);
    sf(CMD_PROG, 24'h000010, 6, 0, 1'b0);
    rc(A_STAT, 32'h1, 32'h1);
    k = 0;
    r = 16'h1;
    while (r[0] && k < 20) begin
      sf(CMD_STATUS, 24'h0, 1, 1, 1'b0);
      k++;
    end
    chk({31'h0, r[0]}, 32'h0);
    if (r[0]) end_sim();
    rc(A_ISTS, 32'h2, 32'h2);
    sf(CMD_READ, 24'h000010, 4, 2, 1'b0);
    chk({16'h0, r}, 32'ha53c);
    sf(CMD_RD_ID, 24'h0, 4, 2, 1'b0);
    chk({16'h0, r}, {16'h0, ID_VAL[63:48]});
  endtask
  // Page wrap, suspend, wrapped burst and read lock
  task automatic t_more();
    sf(CMD_WRITE_EN, 24'h0, 1, 0, 1'b0);
    sf(CMD_PROG, 24'h0000ff, 6, 0, 1'b0);
    sf(CMD_SUSPEND, 24'h0, 1, 0, 1'b0);
    rc(A_STAT, 32'h5, 32'h5);
    repeat (300) @(posedge ref_clk);
    rc(A_STAT, 32'h1, 32'h1);
    sf(CMD_RESUME, 24'h0, 1, 0, 1'b0);
    repeat (300) @(posedge ref_clk);
    rc(A_STAT, 32'h5, 32'h0);
    sf(CMD_READ, 24'h000000, 4, 1, 1'b0);
    chk({24'h0, r[7:0]}, 32'h3c);
    sf(CMD_SET_WRAP, 24'h010000, 2, 0, 1'b0);
    sf(CMD_READ_WRAP, 24'h00000f, 4, 2, 1'b0);
    chk({24'h0, r[7:0]}, 32'h3c);
    sf(CMD_WRITE_EN, 24'h0, 1, 0, 1'b0);
    sf(CMD_WR_PROT, 24'h040000, 2, 0, 1'b0);
    sf(CMD_READ, 24'h000010, 4, 2, 1'b0);
    chk({16'h0, r}, 32'h0);
    sf(CMD_WRITE_EN, 24'h0, 1, 0, 1'b0);
    sf(CMD_WR_PROT, 24'h0, 2, 0, 1'b0);
    rc(A_STAT, 32'hf0, 32'h0);
  endtask
  task automatic t_guard();
    pause_pin_n <= 1'b0;
    sf(CMD_WRITE_EN, 24'h0, 1, 0, 1'b0);
    rc(A_STAT, 32'h2, 32'h0);
    pause_pin_n <= 1'b1;
    wb(1'b1, A_CTRL, 32'h1);
    guard_n <= 1'b0;
    wb(1'b1, A_ICLR, 32'h7);
    sf(CMD_WRITE_EN, 24'h0, 1, 0, 1'b0);
    sf(CMD_WR_PROT, 24'h0f0000, 2, 0, 1'b0);
    rc(A_ISTS, 32'h4, 32'h4);
    rc(A_STAT, 32'hf0, 32'h0);
  endtask
  task automatic t_quad();
    sf(CMD_ENTER_QUAD, 24'h0, 1, 0, 1'b0);
    rc(A_STAT, 32'h8, 32'h8);
    sf(CMD_WRITE_EN, 24'h0, 1, 0, 1'b1);
    sf(CMD_WR_PROT, 24'h030000, 2, 0, 1'b1);
    rc(A_STAT, 32'hf0, 32'h30);
    sf(CMD_READ, 24'h000010, 4, 2, 1'b1);
    chk({16'h0, r}, 32'ha53c);
    sf(CMD_LEAVE_QUAD, 24'h0, 1, 0, 1'b1);
    rc(A_STAT, 32'h8, 32'h0);
    guard_n <= 1'b1;
  endtask
  initial begin
    nrst = 1'b0;
    pause_pin_n = 1'b1;
    guard_n = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_dat = 32'h0;
    fails = 0;
    check_count = 0;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_reset();
    t_irq();
    t_prog();
    t_more();
    t_guard();
    t_quad();
    end_sim();
  end
endmodule
